// ===== logic/pic_pkg.sv
/*
  Shared constants and types of the priority interrupt controller:
  source indices, vector addresses, priority ranks and latency counts.
  Assumes a 20 MHz core clock and a core that reports instruction boundaries.
*/
`default_nettype none

package pic_pkg;

  // ---------------------------------------------------------------
  // sources, in polling order (0 is polled first)
  // ---------------------------------------------------------------
  localparam int NUM_SRC = 13;
  localparam logic [3:0] SRC_PSM = 4'h0;
  localparam logic [3:0] SRC_RTC = 4'h1;
  localparam logic [3:0] SRC_DSP = 4'h2;
  localparam logic [3:0] SRC_WDT = 4'h3;
  localparam logic [3:0] SRC_TEMP = 4'h4;
  localparam logic [3:0] SRC_EXT0 = 4'h5;
  localparam logic [3:0] SRC_TMR0 = 4'h6;
  localparam logic [3:0] SRC_EXT1 = 4'h7;
  localparam logic [3:0] SRC_TMR1 = 4'h8;
  localparam logic [3:0] SRC_SER = 4'h9;
  localparam logic [3:0] SRC_UART = 4'hA;
  localparam logic [3:0] SRC_TMR2 = 4'hB;
  localparam logic [3:0] SRC_UART2 = 4'hC;

  // ---------------------------------------------------------------
  // priority ranks: 0 none, 1 low, 2 high, 3 power supply
  // ---------------------------------------------------------------
  localparam logic [1:0] RANK_NONE = 2'h0;
  localparam logic [1:0] RANK_LOW = 2'h1;
  localparam logic [1:0] RANK_HIGH = 2'h2;
  localparam logic [1:0] RANK_PSM = 2'h3;

  // ---------------------------------------------------------------
  // latency figures
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int MIN_LAT_NS = 800;
  localparam int MAX_LAT_NS = 4000;
  localparam int MIN_LAT_CYC = (MIN_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_LAT_CYC = MAX_LAT_NS / CLK_PERIOD_NS;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_DELAY = 1'b1
  } pic_state_type;

  // raw requests and flags from the peripherals
  typedef struct packed {
    logic power_supply_request;
    logic rtc_alarm_flag;
    logic rtc_interval_flag;
    logic energy_dsp_request;
    logic watchdog_timeout_flag;
    logic temperature_adc_request;
    logic timer0_overflow_flag;
    logic timer1_overflow_flag;
    logic serial_bus_request;
    logic [1:0] uart_rx_tx_flags;
    logic [1:0] timer2_flags;
    logic [1:0] uart2_rx_tx_flags;
  } pic_src_type;

  function automatic logic [15:0] vec_of(input logic [3:0] src);
    unique case (src)
      SRC_EXT0: vec_of = 16'h0003;
      SRC_TMR0: vec_of = 16'h000B;
      SRC_EXT1: vec_of = 16'h0013;
      SRC_TMR1: vec_of = 16'h001B;
      SRC_UART: vec_of = 16'h0023;
      SRC_TMR2: vec_of = 16'h002B;
      SRC_TEMP: vec_of = 16'h0033;
      SRC_SER: vec_of = 16'h003B;
      SRC_PSM: vec_of = 16'h0043;
      SRC_DSP: vec_of = 16'h004B;
      SRC_RTC: vec_of = 16'h0053;
      SRC_WDT: vec_of = 16'h005B;
      SRC_UART2: vec_of = 16'h0063;
      default: vec_of = 16'h0000;
    endcase
  endfunction : vec_of

endpackage : pic_pkg

`default_nettype wire

// ===== logic/pic_ctrl.sv
/*
  Priority interrupt controller: latches and resolves thirteen requests,
  hands one vector at a time to the core and tracks the levels in service.
  Assumes the core pulses instr_boundary once per instruction, return_from_interrupt_done on a
  return from interrupt and ie_ip_access on an enable or priority access.
*/
// Notes on behaviour
// - equal-level requests served in fixed polling order, index 0 first.
// - power supply request alone at top level, above both configurable levels.
// - on acceptance push program counter and load the source vector.
// - each source has its own fixed vector address.
// - return from interrupt restores program counter and releases active level.
// - no vectoring right after return or enable/priority access; one instruction first.
// - at least 3.25 instruction cycles from request to routine entry.
// - high-priority latency never exceeds 16.25 instruction cycles.
// - hardware saves only the program counter; routine saves all else.
// - external wake-up from core-off mode leaves a pending external interrupt.
// - external request flags untouched by events while core is off.
// - temperature and serial bus requests latched, cleared only by entry.
// - latched requests wait while disabled, served soon after enabling.
// - RTC request follows alarm and interval flags; entry alone keeps it.
// - multi-source vectors are not cleared by entry; software clears them.
// - external flags auto-clear on entry only in edge mode.
// - level mode keeps reasserting until the pin returns high.
// - temperature request shows no flag to software and is masked out of pending status.
// - high preempts low; no request preempts its own level.
// - global enable gates every source regardless of own enables.
// - per-source priority bit selects high (1) or low (0); ignored for the power supply source.
`default_nettype none

module pic_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // peripheral requests and external pins (active low)
  input wire pic_pkg::pic_src_type src_in,
  input wire logic ext0_pin_n,
  input wire logic ext1_pin_n,
  // configuration
  input wire logic global_interrupt_enable,
  input wire logic [12:0] source_enable,
  input wire logic [12:0] source_high_priority,
  input wire logic external0_edge_select,
  input wire logic external1_edge_select,
  input wire logic core_off_power_mode,
  // software clears of the external flags
  input wire logic ext0_flag_clear,
  input wire logic ext1_flag_clear,
  // core handshake
  input wire logic instr_boundary,
  input wire logic return_from_interrupt_done,
  input wire logic ie_ip_access,
  // vector to the core
  output logic take_ff,
  output logic push_pc_ff,
  output logic [15:0] vector_addr_ff,
  output logic [3:0] vector_src_ff,
  output logic [1:0] vector_rank_ff,
  // status
  output logic external0_request_flag,
  output logic external1_request_flag,
  output logic [1:0] timer_flag_clear_ff,
  output logic [12:0] pending_status_ff,
  output logic [2:0] in_service_ff,
  output logic latency_exceeded_ff
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pic_pkg::pic_state_type state_ff;
  logic ext0_flag_ff, ext1_flag_ff, wake0_ff, wake1_ff;
  logic ext0_prev_ff, ext1_prev_ff, temp_pend_ff, ser_pend_ff, block_ff;
  logic [4:0] delay_ff;
  logic [6:0] wait_ff;
  logic [12:0] pend, elig;
  logic [1:0] act_rank, win_rank;
  logic [3:0] win_src;
  logic win_found, dispatch_start, take_now, ext0_fall, ext1_fall;

  assign external0_request_flag = ext0_flag_ff;
  assign external1_request_flag = ext1_flag_ff;
  assign ext0_fall = ext0_prev_ff & ~ext0_pin_n;
  assign ext1_fall = ext1_prev_ff & ~ext1_pin_n;
  assign take_now = (state_ff == pic_pkg::ST_DELAY) && (delay_ff == 5'h00);

  function automatic logic [1:0] rank_of(input logic [3:0] idx, input logic hi);
    rank_of = (idx == pic_pkg::SRC_PSM) ? pic_pkg::RANK_PSM :
              (hi ? pic_pkg::RANK_HIGH : pic_pkg::RANK_LOW);
  endfunction : rank_of

  // ---------------------------------------------------------------
  // request vector
  // ---------------------------------------------------------------
  always_comb begin
    pend = 13'h0000;
    pend[pic_pkg::SRC_PSM] = src_in.power_supply_request;
    pend[pic_pkg::SRC_RTC] = src_in.rtc_alarm_flag | src_in.rtc_interval_flag;
    pend[pic_pkg::SRC_DSP] = src_in.energy_dsp_request;
    pend[pic_pkg::SRC_WDT] = src_in.watchdog_timeout_flag;
    pend[pic_pkg::SRC_TEMP] = temp_pend_ff;
    pend[pic_pkg::SRC_EXT0] = ext0_flag_ff | wake0_ff;
    pend[pic_pkg::SRC_TMR0] = src_in.timer0_overflow_flag;
    pend[pic_pkg::SRC_EXT1] = ext1_flag_ff | wake1_ff;
    pend[pic_pkg::SRC_TMR1] = src_in.timer1_overflow_flag;
    pend[pic_pkg::SRC_SER] = ser_pend_ff;
    pend[pic_pkg::SRC_UART] = |src_in.uart_rx_tx_flags;
    pend[pic_pkg::SRC_TMR2] = |src_in.timer2_flags;
    pend[pic_pkg::SRC_UART2] = |src_in.uart2_rx_tx_flags;
  end

  // ---------------------------------------------------------------
  // priority resolution
  // ---------------------------------------------------------------
  always_comb begin
    act_rank = pic_pkg::RANK_NONE;
    if (in_service_ff[0]) act_rank = pic_pkg::RANK_LOW;
    if (in_service_ff[1]) act_rank = pic_pkg::RANK_HIGH;
    if (in_service_ff[2]) act_rank = pic_pkg::RANK_PSM;
  end

  always_comb begin
    win_found = 1'b0;
    win_src = 4'h0;
    win_rank = pic_pkg::RANK_NONE;
    elig = global_interrupt_enable ? (pend & source_enable) : 13'h0000;
    // psm on top; priority bit picks level
    for (int r = 3; r >= 1; r--) begin
      for (int i = 0; i < pic_pkg::NUM_SRC; i++) begin
        if (!win_found && elig[i] &&
            rank_of(4'(i), source_high_priority[i]) == 2'(r)) begin
          win_found = 1'b1;
          win_src = 4'(i);
          win_rank = 2'(r);
        end
      end
    end
  end

  // only a higher rank preempts; decided at the boundary
  assign dispatch_start = (state_ff == pic_pkg::ST_IDLE) && instr_boundary && win_found &&
                          (win_rank > act_rank) && !block_ff && !return_from_interrupt_done && !ie_ip_access;

  // ---------------------------------------------------------------
  // one instruction gap after return or enable/priority access
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      block_ff <= 1'b0;
    end else if (return_from_interrupt_done || ie_ip_access) begin
      block_ff <= 1'b1;
    end else if (instr_boundary) begin
      block_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // dispatch sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_ff <= pic_pkg::ST_IDLE;
      delay_ff <= 5'h00;
      take_ff <= 1'b0;
      push_pc_ff <= 1'b0;
      vector_addr_ff <= 16'h0000;
      vector_src_ff <= 4'h0;
      vector_rank_ff <= pic_pkg::RANK_NONE;
    end else begin
      take_ff <= 1'b0;
      push_pc_ff <= 1'b0;
      unique case (state_ff)
        pic_pkg::ST_IDLE: begin
          if (dispatch_start) begin
            state_ff <= pic_pkg::ST_DELAY;
            delay_ff <= 5'(pic_pkg::MIN_LAT_CYC - 2);
            vector_src_ff <= win_src;
            vector_rank_ff <= win_rank;
          end
        end
        pic_pkg::ST_DELAY: begin
          if (delay_ff == 5'h00) begin
            state_ff <= pic_pkg::ST_IDLE;
            // push pc, load vector; pc only
            take_ff <= 1'b1;
            push_pc_ff <= 1'b1;
            vector_addr_ff <= pic_pkg::vec_of(vector_src_ff);
          end else begin
            delay_ff <= delay_ff - 5'h01;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // levels in service
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      in_service_ff <= 3'h0;
    end else if (take_now) begin
      in_service_ff[vector_rank_ff - 2'h1] <= 1'b1;
    end else if (return_from_interrupt_done) begin
      if (in_service_ff[2]) in_service_ff[2] <= 1'b0;
      else if (in_service_ff[1]) in_service_ff[1] <= 1'b0;
      else in_service_ff[0] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // latched requests and auto clears
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      temp_pend_ff <= 1'b0;
      ser_pend_ff <= 1'b0;
      timer_flag_clear_ff <= 2'h0;
    end else begin
      // cleared only by entry, a new request wins; held while disabled
      if (src_in.temperature_adc_request) temp_pend_ff <= 1'b1;
      else if (take_now && vector_src_ff == pic_pkg::SRC_TEMP) temp_pend_ff <= 1'b0;
      if (src_in.serial_bus_request) ser_pend_ff <= 1'b1;
      else if (take_now && vector_src_ff == pic_pkg::SRC_SER) ser_pend_ff <= 1'b0;
      // only single-flag timers cleared on entry
      timer_flag_clear_ff[0] <= take_now && vector_src_ff == pic_pkg::SRC_TMR0;
      timer_flag_clear_ff[1] <= take_now && vector_src_ff == pic_pkg::SRC_TMR1;
    end
  end

  // ---------------------------------------------------------------
  // external interrupt flags
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ext0_prev_ff <= 1'b1;
      ext1_prev_ff <= 1'b1;
      ext0_flag_ff <= 1'b0;
      ext1_flag_ff <= 1'b0;
      wake0_ff <= 1'b0;
      wake1_ff <= 1'b0;
    end else begin
      ext0_prev_ff <= ext0_pin_n;
      ext1_prev_ff <= ext1_pin_n;
      if (core_off_power_mode) begin
        if (!ext0_pin_n) wake0_ff <= 1'b1;
        if (!ext1_pin_n) wake1_ff <= 1'b1;
      end else begin
        if (take_now && vector_src_ff == pic_pkg::SRC_EXT0) wake0_ff <= 1'b0;
        if (take_now && vector_src_ff == pic_pkg::SRC_EXT1) wake1_ff <= 1'b0;
        if (!external0_edge_select) ext0_flag_ff <= ~ext0_pin_n;
        else if (ext0_fall) ext0_flag_ff <= 1'b1;
        else if (ext0_flag_clear || (take_now && vector_src_ff == pic_pkg::SRC_EXT0))
          ext0_flag_ff <= 1'b0;
        if (!external1_edge_select) ext1_flag_ff <= ~ext1_pin_n;
        else if (ext1_fall) ext1_flag_ff <= 1'b1;
        else if (ext1_flag_clear || (take_now && vector_src_ff == pic_pkg::SRC_EXT1))
          ext1_flag_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // status and latency monitor
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pending_status_ff <= 13'h0000;
      wait_ff <= 7'h00;
      latency_exceeded_ff <= 1'b0;
    end else begin
      pending_status_ff <= pend & ~(13'h0001 << pic_pkg::SRC_TEMP);
      // flag a high request waiting past the bound
      if (!win_found || win_rank < pic_pkg::RANK_HIGH || take_now) begin
        wait_ff <= 7'h00;
      end else if (wait_ff != 7'(pic_pkg::MAX_LAT_CYC)) begin
        wait_ff <= wait_ff + 7'h01;
      end
      latency_exceeded_ff <= (wait_ff == 7'(pic_pkg::MAX_LAT_CYC));
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  localparam int MIN_GAP = pic_pkg::MIN_LAT_CYC;

  sequence s_dispatch;
    dispatch_start ##1 (state_ff == pic_pkg::ST_DELAY);
  endsequence

  a_vector_address: assert property (take_ff |-> vector_addr_ff == pic_pkg::vec_of(vector_src_ff))
    else $error("vector address does not match source");
  a_min_latency: assert property (s_dispatch |-> !take_ff [*8] ##0 1'b1)
    else $error("vector taken too early");
  a_take_spacing: assert property ($rose(take_ff) |-> $past(dispatch_start, MIN_GAP))
    else $error("take not minimum latency after dispatch");
  a_block_gap: assert property (dispatch_start |-> !$past(return_from_interrupt_done) && !$past(ie_ip_access))
    else $error("vectoring right after return or access");
  a_global_gate: assert property (!global_interrupt_enable |-> !dispatch_start)
    else $error("dispatch with global enable clear");
  a_no_same_level: assert property (dispatch_start
    |-> (in_service_ff >> (win_rank - 2'h1)) == 3'h0)
    else $error("preempted own level");
  a_temp_latched: assert property (temp_pend_ff && !take_now |=> temp_pend_ff)
    else $error("temperature request lost");
  a_rtc_cancel: assert property (!(src_in.rtc_alarm_flag || src_in.rtc_interval_flag)
    |=> !pending_status_ff[pic_pkg::SRC_RTC])
    else $error("rtc pending without flags");
  a_multi_kept: assert property (take_now && vector_src_ff >= pic_pkg::SRC_UART
    |=> timer_flag_clear_ff == 2'h0)
    else $error("multi-source vector cleared");
  a_core_off_flags: assert property (core_off_power_mode |=> $stable(ext0_flag_ff)
    && $stable(ext1_flag_ff))
    else $error("external flag changed while core off");
  a_psm_first: assert property (dispatch_start && elig[pic_pkg::SRC_PSM]
    |-> win_src == pic_pkg::SRC_PSM)
    else $error("power supply request not first");

endmodule : pic_ctrl

`default_nettype wire

// ===== tb/pic_core_model.sv
/*
  Behavioural core for the interrupt controller: marks instruction
  boundaries, keeps a program counter stack and issues returns and
  enable or priority accesses on request of the bench.
  Assumes the controller pulses push_pc_ff with a valid vector address.
*/
`default_nettype none

module pic_core_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // from the controller
  input wire logic push_pc_ff,
  input wire logic [15:0] vector_addr_ff,
  // from the bench
  input wire logic core_off,
  input wire logic return_from_interrupt_req,
  input wire logic access_req,
  // to the controller and bench
  output logic instr_boundary,
  output logic return_from_interrupt_done,
  output logic ie_ip_access,
  output logic [3:0] stack_depth
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_ff;
  logic return_from_interrupt_pend_ff;
  logic acc_pend_ff;
  logic [15:0] pc_ff;
  logic [15:0] stack_ff [16];

  // boundaries stop while the core is off
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      phase_ff <= 2'h0;
      instr_boundary <= 1'b0;
      return_from_interrupt_pend_ff <= 1'b0;
      acc_pend_ff <= 1'b0;
      return_from_interrupt_done <= 1'b0;
      ie_ip_access <= 1'b0;
    end else begin
      if (!core_off) phase_ff <= phase_ff + 2'h1;
      instr_boundary <= !core_off && phase_ff == 2'h3;
      return_from_interrupt_pend_ff <= return_from_interrupt_req || (return_from_interrupt_pend_ff && phase_ff != 2'h1);
      acc_pend_ff <= access_req || (acc_pend_ff && phase_ff != 2'h1);
      return_from_interrupt_done <= return_from_interrupt_pend_ff && phase_ff == 2'h1;
      ie_ip_access <= acc_pend_ff && phase_ff == 2'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pc_ff <= 16'h0100;
      stack_depth <= 4'h0;
    end else if (push_pc_ff) begin
      stack_ff[stack_depth] <= pc_ff;
      pc_ff <= vector_addr_ff;
      stack_depth <= stack_depth + 4'h1;
    end else if (return_from_interrupt_done) begin
      pc_ff <= stack_ff[stack_depth - 4'h1];
      stack_depth <= stack_depth - 4'h1;
    end
  end
endmodule : pic_core_model

`default_nettype wire

// ===== tb/priority_interrupt_controller_test.sv
/*
  Self-checking bench of pic_ctrl: drives requests and configuration,
  queues expected dispatches and compares them as they appear.
  Assumes pic_pkg, pic_ctrl and pic_core_model are compiled first.
*/
`default_nettype none

module priority_interrupt_controller_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  pic_pkg::pic_src_type src_in = '0;
  logic ext0_pin_n = 1'b1;
  logic ext1_pin_n = 1'b1;
  logic glb_en = 1'b0;
  logic [12:0] src_en = 13'h0000;
  logic [12:0] src_hi = 13'h0000;
  logic [1:0] edge_sel = 2'h3;
  logic core_off = 1'b0;
  logic return_from_interrupt_req = 1'b0;
  logic acc_req = 1'b0;
  logic instr_boundary, return_from_interrupt_done, ie_ip_access, take_ff, push_pc_ff, ext0_flag, ext1_flag;
  logic [15:0] vector_addr_ff;
  logic [1:0] vector_rank_ff, tmr_clr;
  logic [12:0] pend;
  logic [3:0] depth, vector_src_ff;
  logic [2:0] in_svc;
  logic lat_ex;
  int miscompares = 0;
  int n_compared = 0;
  int seed = 32'hB005;
  int n;
  int ord[$];
  logic [21:0] exp_q[$];
  logic [15:0] vec_tab [13] = '{16'h0043, 16'h0053, 16'h004B, 16'h005B, 16'h0033,
    16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0063};

  always #25 ref_clk = ~ref_clk;

  pic_ctrl dut (.ref_clk(ref_clk), .reset_n(reset_n), .src_in(src_in),
    .ext0_pin_n(ext0_pin_n), .ext1_pin_n(ext1_pin_n), .global_interrupt_enable(glb_en),
    .source_enable(src_en), .source_high_priority(src_hi),
    .external0_edge_select(edge_sel[0]), .external1_edge_select(edge_sel[1]),
    .core_off_power_mode(core_off), .ext0_flag_clear(1'b0), .ext1_flag_clear(1'b0),
    .instr_boundary(instr_boundary), .return_from_interrupt_done(return_from_interrupt_done), .ie_ip_access(ie_ip_access),
    .take_ff(take_ff), .push_pc_ff(push_pc_ff), .vector_addr_ff(vector_addr_ff),
    .vector_src_ff(vector_src_ff), .vector_rank_ff(vector_rank_ff),
    .external0_request_flag(ext0_flag),
    .external1_request_flag(ext1_flag), .timer_flag_clear_ff(tmr_clr),
    .pending_status_ff(pend), .in_service_ff(in_svc), .latency_exceeded_ff(lat_ex));

  pic_core_model core (.ref_clk(ref_clk), .reset_n(reset_n), .push_pc_ff(push_pc_ff),
    .vector_addr_ff(vector_addr_ff), .core_off(core_off), .return_from_interrupt_req(return_from_interrupt_req),
    .access_req(acc_req), .instr_boundary(instr_boundary), .return_from_interrupt_done(return_from_interrupt_done),
    .ie_ip_access(ie_ip_access), .stack_depth(depth));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic set_src(input int i, input logic v);
    case (i)
      0: src_in.power_supply_request = v;
      1: src_in.rtc_alarm_flag = v;
      2: src_in.energy_dsp_request = v;
      3: src_in.watchdog_timeout_flag = v;
      4: src_in.temperature_adc_request = v;
      5: ext0_pin_n = !v;
      6: src_in.timer0_overflow_flag = v;
      7: ext1_pin_n = !v;
      8: src_in.timer1_overflow_flag = v;
      9: src_in.serial_bus_request = v;
      10: src_in.uart_rx_tx_flags = {1'b0, v};
      11: src_in.timer2_flags = {v, 1'b0};
      default: src_in.uart2_rx_tx_flags = {v, v};
    endcase
  endtask : set_src

  // pulse sources and pins are released after one cycle
  task automatic raise(input logic [12:0] m);
    for (int i = 0; i < 13; i++) if (m[i]) set_src(i, 1'b1);
    @(negedge ref_clk);
    for (int i = 4; i < 10; i++) if (i != 6 && i != 8) set_src(i, 1'b0);
  endtask : raise

  function automatic logic [21:0] exp_of(input int i);
    logic [1:0] r;
    r = (i == 0) ? 2'h3 : (src_hi[i] ? 2'h2 : 2'h1);
    return {4'(i), r, vec_tab[i]};
  endfunction : exp_of

  task automatic wait_take();
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (take_ff !== 1'b1 && n < 300);
    if (take_ff !== 1'b1) begin
      miscompares++;
      $display("unexpected timeout at %0t waiting for a dispatch", $time);
      final_report();
    end
  endtask : wait_take

  task automatic do_return_from_interrupt();
    return_from_interrupt_req = 1'b1;
    @(negedge ref_clk);
    return_from_interrupt_req = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask : do_return_from_interrupt

  // checks request state after entry, then clears as software would
  task automatic after_entry(input int i);
    repeat (5) @(negedge ref_clk);
    check(pend[i], !(i inside {[4:9]}));
    set_src(i, 1'b0);
    repeat (3) @(negedge ref_clk);
    check(pend[i], 1'b0);
  endtask : after_entry

  always @(negedge ref_clk) begin
    if (tmr_clr[0] === 1'b1) src_in.timer0_overflow_flag = 1'b0;
    if (tmr_clr[1] === 1'b1) src_in.timer1_overflow_flag = 1'b0;
    if (take_ff === 1'b1) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("unexpected dispatch at %0t", $time);
      end else begin
        check({vector_src_ff, vector_rank_ff, vector_addr_ff}, exp_q.pop_front());
      end
      check(push_pc_ff, 1'b1);
      check(lat_ex, 1'b0);
    end
  end

  initial begin
    repeat (4) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    // all sources at once, served by rank then polling order
    glb_en = 1'b1;
    src_en = 13'h1FFF;
    src_hi = 13'($random(seed));
    for (int r = 3; r > 0; r--) begin
      for (int i = 0; i < 13; i++) begin
        if ((exp_of(i) >> 16) % 4 == r) ord.push_back(i);
      end
    end
    foreach (ord[k]) exp_q.push_back(exp_of(ord[k]));
    raise(13'h1FFF);
    foreach (ord[k]) begin
      wait_take();
      // the raise call already spent one cycle of the latency
      if (k == 0) check(n + 1 >= pic_pkg::MIN_LAT_CYC, 1'b1);
      if (k == 0) check(n < pic_pkg::MAX_LAT_CYC, 1'b1);
      after_entry(ord[k]);
      do_return_from_interrupt();
    end
    // preemption by higher levels only
    src_hi = 13'h0004;
    exp_q.push_back(exp_of(8));
    raise(13'h0100);
    wait_take();
    raise(13'h0040);
    repeat (40) @(negedge ref_clk);
    exp_q.push_back(exp_of(2));
    raise(13'h0004);
    wait_take();
    exp_q.push_back(exp_of(0));
    raise(13'h0001);
    wait_take();
    // the core pushes on the edge after the take pulse
    @(negedge ref_clk);
    check(depth, 4'h3);
    check(in_svc, 3'h7);
    set_src(0, 1'b0);
    do_return_from_interrupt();
    set_src(2, 1'b0);
    do_return_from_interrupt();
    exp_q.push_back(exp_of(6));
    do_return_from_interrupt();
    wait_take();
    do_return_from_interrupt();
    // latched serial request held by global and own enables
    glb_en = 1'b0;
    raise(13'h0200);
    repeat (40) @(negedge ref_clk);
    glb_en = 1'b1;
    src_en[9] = 1'b0;
    repeat (40) @(negedge ref_clk);
    exp_q.push_back(exp_of(9));
    src_en[9] = 1'b1;
    acc_req = 1'b1;
    @(negedge ref_clk);
    acc_req = 1'b0;
    wait_take();
    repeat (2) @(negedge ref_clk);
    check(pend[9], 1'b0);
    do_return_from_interrupt();
    // wake from core off leaves a pending external request
    core_off = 1'b1;
    raise(13'h0020);
    repeat (4) @(negedge ref_clk);
    check(ext0_flag, 1'b0);
    exp_q.push_back(exp_of(5));
    core_off = 1'b0;
    wait_take();
    do_return_from_interrupt();
    // level mode re-enters until the pin returns high
    edge_sel = 2'h1;
    exp_q.push_back(exp_of(7));
    exp_q.push_back(exp_of(7));
    set_src(7, 1'b1);
    wait_take();
    do_return_from_interrupt();
    wait_take();
    set_src(7, 1'b0);
    repeat (3) @(negedge ref_clk);
    check(ext1_flag, 1'b0);
    do_return_from_interrupt();
    repeat (60) @(negedge ref_clk);
    check(exp_q.size(), 0);
    check(depth, 4'h0);
    check(in_svc, 3'h0);
    final_report();
  end
endmodule : priority_interrupt_controller_test

`default_nettype wire
